// *** rtl/rsbc_top.sv ***
// Reset source, brown-out control and power-up delay sequencing.
// Assumes supply comparators and the reset pin are asynchronous levels;
// configuration is static fuse-like input straps.
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/100ps

// Summary of operation
// - Filtered low on the reset pin resets; short glitches are ignored.
// - Reset pin is input only; internal resets never drive it.
// - With pin disabled, pin is a plain input, no reset.
// - Supply rising above threshold makes a power-on reset pulse.
// - Power-on flag cleared on power-on reset only.
// - Hardware never sets the power-on flag; software writes it one.
// - Detector enabled: resets when supply low longer than minimum time.
// - Brown-out reset holds until supply is back above threshold.
// - Delay timer runs after recovery; new brown-out restarts it.
// - Brown-out enable and delay timer enable are independent.
// - Mode 01: software enable bit turns detector on or off.
// - Software enable works only in mode 01, else reads zero.
// - Threshold comes only from the level configuration field.
// - Brown-out flag cleared on brown-out and power-on resets.
// - Mode 10: detector off in sleep, on otherwise.
// - Mode 00: brown-out reset always disabled.
// - Mode 11: brown-out reset always enabled.
// - Delay is 11-bit count of 32 us oscillator ticks, reset held.
// - Delay runs only when its disable_n bit is clear.
// - Delay follows end of power-on pulse, then start-up timer.
module rsbc_top #(
    parameter int RC_TICK = rsbc_pkg::RC_TICK_CYC,
    parameter int POWERUP_DELAY_TIMER_COUNT = 2 ** rsbc_pkg::POWERUP_DELAY_TIMER_BITS
) (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic EXT_RESET_N,
    input wire logic SUPPLY_OK,
    input wire logic BOR_SUPPLY_LOW,
    input wire logic SLEEP_MODE,
    input wire rsbc_pkg::rsbc_cfg_t CFG,
    output logic [1:0] BOR_LEVEL_SEL,
    output logic EXT_PIN_DATA,
    output logic DEVICE_RESET,
    output logic OST_START,
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);

    typedef enum logic [1:0] {
        RSBC_POR, RSBC_BOR, RSBC_POWERUP_DELAY_TIMER, RSBC_RUN
    } rsbc_state_t;

    localparam logic [15:0] RC_TICK_W = 16'(RC_TICK - 1);
    localparam logic [11:0] POWERUP_DELAY_TIMER_LAST = 12'(POWERUP_DELAY_TIMER_COUNT - 1);
    localparam logic [3:0] FILT_LAST = 4'(rsbc_pkg::FILT_CYC - 1);
    localparam logic [3:0] BROWNOUT_MIN_DURATION_LAST = 4'(rsbc_pkg::BROWNOUT_MIN_DURATION_CYC - 1);
    localparam logic [2:0] PORP_LAST = 3'(rsbc_pkg::POR_PULSE_CYC - 1);

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers.

    logic [1:0] pin_sync_reg;
    logic [1:0] sup_sync_reg;
    logic [1:0] low_sync_reg;
    logic [1:0] slp_sync_reg;

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            pin_sync_reg <= 2'h3;
            sup_sync_reg <= 2'h0;
            low_sync_reg <= 2'h0;
            slp_sync_reg <= 2'h0;
        end else begin
            pin_sync_reg <= {pin_sync_reg[0], EXT_RESET_N};
            sup_sync_reg <= {sup_sync_reg[0], SUPPLY_OK};
            low_sync_reg <= {low_sync_reg[0], BOR_SUPPLY_LOW};
            slp_sync_reg <= {slp_sync_reg[0], SLEEP_MODE};
        end
    end

    wire logic pin_s = pin_sync_reg[1];
    wire logic sup_s = sup_sync_reg[1];
    wire logic low_s = low_sync_reg[1];
    wire logic slp_s = slp_sync_reg[1];

    ////////////////////////////////////////////////////////////////////
    // Reset pin noise filter.

    logic [3:0] filt_cnt_reg;
    logic pin_reset_reg;

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            filt_cnt_reg <= 4'h0;
            pin_reset_reg <= 1'b0;
        end else if (pin_s) begin
            filt_cnt_reg <= 4'h0;
            pin_reset_reg <= 1'b0;
        end else if (filt_cnt_reg == FILT_LAST) begin
            pin_reset_reg <= CFG.ext_reset_pin_enable;
        end else begin
            filt_cnt_reg <= filt_cnt_reg + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Brown-out enable and detector.

    logic sw_brownout_enable_reg;
    logic [3:0] brownout_min_duration_cnt_reg;
    logic bor_trip_reg;
    logic bor_en;

    always_comb begin
        case (CFG.brownout_mode_cfg)
            rsbc_pkg::BOR_SW: bor_en = sw_brownout_enable_reg;
            rsbc_pkg::BOR_NOSLEEP: bor_en = !slp_s;
            rsbc_pkg::BOR_ON: bor_en = 1'b1;
            default: bor_en = 1'b0;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            brownout_min_duration_cnt_reg <= 4'h0;
            bor_trip_reg <= 1'b0;
        end else if (!bor_en || !low_s) begin
            brownout_min_duration_cnt_reg <= 4'h0;
            bor_trip_reg <= 1'b0;
        end else if (brownout_min_duration_cnt_reg == BROWNOUT_MIN_DURATION_LAST) begin
            bor_trip_reg <= 1'b1;
        end else begin
            brownout_min_duration_cnt_reg <= brownout_min_duration_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            BOR_LEVEL_SEL <= 2'h0;
        end else begin
            BOR_LEVEL_SEL <= CFG.brownout_level_cfg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sequencer: power-on pulse, brown-out hold, power-up delay.

    rsbc_state_t state_reg;
    logic [2:0] porp_cnt_reg;
    logic [15:0] tick_cnt_reg;
    logic [11:0] powerup_delay_timer_cnt_reg;
    logic sup_prev_reg;
    logic por_event;
    logic bor_event;
    wire logic rc_tick = (tick_cnt_reg == RC_TICK_W);

    assign por_event = sup_s && !sup_prev_reg;
    assign bor_event = bor_trip_reg && state_reg != RSBC_BOR;

    // The oscillator divider stands in for the internal RC clock.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            tick_cnt_reg <= 16'h0;
        end else if (state_reg != RSBC_POWERUP_DELAY_TIMER || rc_tick) begin
            tick_cnt_reg <= 16'h0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 16'h1;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_reg <= RSBC_POR;
            porp_cnt_reg <= 3'h0;
            powerup_delay_timer_cnt_reg <= 12'h0;
            sup_prev_reg <= 1'b0;
        end else begin
            sup_prev_reg <= sup_s;
            if (!sup_s || por_event) begin
                state_reg <= RSBC_POR;
                porp_cnt_reg <= 3'h0;
                powerup_delay_timer_cnt_reg <= 12'h0;
            end else if (bor_trip_reg) begin
                state_reg <= RSBC_BOR;
                powerup_delay_timer_cnt_reg <= 12'h0;
            end else begin
                case (state_reg)
                    RSBC_POR: begin
                        if (porp_cnt_reg == PORP_LAST) begin
                            state_reg <= CFG.powerup_timer_disable_n ?
                                RSBC_RUN : RSBC_POWERUP_DELAY_TIMER;
                        end else begin
                            porp_cnt_reg <= porp_cnt_reg + 3'h1;
                        end
                    end
                    RSBC_BOR: begin
                        state_reg <= CFG.powerup_timer_disable_n ?
                            RSBC_RUN : RSBC_POWERUP_DELAY_TIMER;
                    end
                    RSBC_POWERUP_DELAY_TIMER: begin
                        if (rc_tick) begin
                            if (powerup_delay_timer_cnt_reg == POWERUP_DELAY_TIMER_LAST) begin
                                state_reg <= RSBC_RUN;
                            end
                            powerup_delay_timer_cnt_reg <= powerup_delay_timer_cnt_reg + 12'h1;
                        end
                    end
                    default: state_reg <= RSBC_RUN;
                endcase
            end
        end
    end

    // pin never driven, no output enable exists
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            DEVICE_RESET <= 1'b1;
            OST_START <= 1'b0;
            EXT_PIN_DATA <= 1'b1;
        end else begin
            DEVICE_RESET <= state_reg != RSBC_RUN || pin_reset_reg;
            OST_START <= (state_reg == RSBC_POR || state_reg == RSBC_POWERUP_DELAY_TIMER)
                && !por_event && sup_s && !bor_trip_reg
                && ((state_reg == RSBC_POWERUP_DELAY_TIMER && rc_tick
                     && powerup_delay_timer_cnt_reg == POWERUP_DELAY_TIMER_LAST)
                    || (state_reg == RSBC_POR
                        && porp_cnt_reg == PORP_LAST
                        && CFG.powerup_timer_disable_n));
            EXT_PIN_DATA <= pin_s;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Flags and software enable.

    logic porf_n_reg;
    logic borf_n_reg;
    logic wr_fire;
    logic [31:0] wdata_hold_reg;
    logic [31:0] waddr_hold_reg;
    logic [3:0] wstrb_hold_reg;
    wire logic ctrl_wr = wr_fire
        && waddr_hold_reg == {28'h0, rsbc_pkg::CTRL_OFFS}
        && wstrb_hold_reg[0];

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            porf_n_reg <= 1'b0;
            borf_n_reg <= 1'b0;
            sw_brownout_enable_reg <= 1'b1;
        end else begin
            // only software sets the power flag
            if (ctrl_wr && wdata_hold_reg[rsbc_pkg::PORF_BIT]) begin
                porf_n_reg <= 1'b1;
            end
            if (ctrl_wr && wdata_hold_reg[rsbc_pkg::BORF_BIT]) begin
                borf_n_reg <= 1'b1;
            end
            if (ctrl_wr) begin
                sw_brownout_enable_reg <= wdata_hold_reg[rsbc_pkg::SW_BROWNOUT_ENABLE_BIT];
            end
            if (por_event) begin
                porf_n_reg <= 1'b0;
                borf_n_reg <= 1'b0;
                sw_brownout_enable_reg <= 1'b1;
            end else if (bor_event) begin
                borf_n_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave.

    logic aw_have_reg;
    logic w_have_reg;
    assign wr_fire = aw_have_reg && w_have_reg && !S_AXI_BVALID;

    // Full address decode, so that upper bits never alias a register.
    function automatic logic known_addr(input logic [31:0] a);
        return a[31:4] == 28'h0 && (a[3:0] == rsbc_pkg::CTRL_OFFS
            || a[3:0] == rsbc_pkg::STAT_OFFS
            || a[3:0] == rsbc_pkg::CFG_OFFS);
    endfunction : known_addr

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            waddr_hold_reg <= 32'h0;
            wdata_hold_reg <= 32'h0;
            wstrb_hold_reg <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= rsbc_pkg::AXI_OKAY;
        end else begin
            S_AXI_AWREADY <= !aw_have_reg && !S_AXI_AWREADY;
            S_AXI_WREADY <= !w_have_reg && !S_AXI_WREADY;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_have_reg <= 1'b1;
                waddr_hold_reg <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_have_reg <= 1'b1;
                wdata_hold_reg <= S_AXI_WDATA;
                wstrb_hold_reg <= S_AXI_WSTRB;
                S_AXI_WREADY <= 1'b0;
            end
            if (wr_fire) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= known_addr(waddr_hold_reg) ?
                    rsbc_pkg::AXI_OKAY : rsbc_pkg::AXI_SLVERR;
            end
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
            end
        end
    end

    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0;
        case (S_AXI_ARADDR[3:0])
            rsbc_pkg::CTRL_OFFS: begin
                rd_word[rsbc_pkg::BORF_BIT] = borf_n_reg;
                rd_word[rsbc_pkg::PORF_BIT] = porf_n_reg;
                rd_word[rsbc_pkg::SW_BROWNOUT_ENABLE_BIT] = sw_brownout_enable_reg
                    && CFG.brownout_mode_cfg == rsbc_pkg::BOR_SW;
            end
            rsbc_pkg::STAT_OFFS: begin
                rd_word[rsbc_pkg::RST_BIT] = DEVICE_RESET;
                rd_word[rsbc_pkg::BOR_ACT_BIT] = bor_en;
                rd_word[rsbc_pkg::POWERUP_DELAY_TIMER_RUN_BIT] = state_reg == RSBC_POWERUP_DELAY_TIMER;
                rd_word[rsbc_pkg::PIN_IN_BIT] = pin_s;
            end
            rsbc_pkg::CFG_OFFS: rd_word[5:0] = CFG;
            default: rd_word = 32'h0;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0;
            S_AXI_RRESP <= rsbc_pkg::AXI_OKAY;
        end else begin
            S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_ARREADY <= 1'b0;
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= known_addr(S_AXI_ARADDR) ? rd_word : 32'h0;
                S_AXI_RRESP <= known_addr(S_AXI_ARADDR) ?
                    rsbc_pkg::AXI_OKAY : rsbc_pkg::AXI_SLVERR;
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks.

    pin_filter_a:
    assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        pin_s |=> !pin_reset_reg)
        else $error("Pin reset outlived high pin.");

    pin_disable_a:
    assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        !CFG.ext_reset_pin_enable |=> !pin_reset_reg)
        else $error("Disabled pin caused reset.");

    por_flag_a:
    assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        por_event |=> !porf_n_reg && !borf_n_reg)
        else $error("Power-on did not clear flags.");

    por_sticky_a:
    assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        !porf_n_reg && !ctrl_wr |=> !porf_n_reg)
        else $error("Power flag set by hardware.");

    bor_off_a:
    assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        CFG.brownout_mode_cfg == rsbc_pkg::BOR_OFF |-> !bor_en)
        else $error("Brown-out enabled in mode 00.");

    bor_trip_a:
    assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        bor_en && low_s && brownout_min_duration_cnt_reg == BROWNOUT_MIN_DURATION_LAST |=> bor_trip_reg)
        else $error("Brown-out did not trip.");

    bor_hold_a:
    assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        state_reg == RSBC_BOR && bor_trip_reg |=> DEVICE_RESET)
        else $error("Reset released during brown-out.");

    sw_read_a:
    assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        CFG.brownout_mode_cfg != rsbc_pkg::BOR_SW
        |-> !rd_word[rsbc_pkg::SW_BROWNOUT_ENABLE_BIT])
        else $error("Software enable read as one.");

    powerup_delay_timer_hold_a:
    assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        state_reg == RSBC_POWERUP_DELAY_TIMER |=> DEVICE_RESET)
        else $error("Reset released while delay counts.");

endmodule : rsbc_top

// *** rtl/rsbc_pkg.sv ***
// Package for the reset source and brown-out control block.
// Assumes a single 50 MHz core clock and an AXI4-Lite register port.
package rsbc_pkg;

    // Register byte offsets.
    localparam logic [3:0] CTRL_OFFS = 4'h0;
    localparam logic [3:0] STAT_OFFS = 4'h4;
    localparam logic [3:0] CFG_OFFS = 4'h8;

    // Control/status register bit positions.
    localparam int BORF_BIT = 0;
    localparam int PORF_BIT = 1;
    localparam int SW_BROWNOUT_ENABLE_BIT = 6;

    // Configuration register fields.
    localparam int MODE_LSB = 0;
    localparam int LEVEL_LSB = 2;
    localparam int POWERUP_DELAY_TIMER_DIS_BIT = 4;
    localparam int PIN_EN_BIT = 5;

    // Status register bits.
    localparam int RST_BIT = 0;
    localparam int BOR_ACT_BIT = 1;
    localparam int POWERUP_DELAY_TIMER_RUN_BIT = 2;
    localparam int PIN_IN_BIT = 3;

    // Brown-out modes.
    localparam logic [1:0] BOR_OFF = 2'h0;
    localparam logic [1:0] BOR_SW = 2'h1;
    localparam logic [1:0] BOR_NOSLEEP = 2'h2;
    localparam logic [1:0] BOR_ON = 2'h3;

    // Timing.
    localparam int CLK_MHZ = 50;
    localparam int FILT_NS = 200;
    localparam int FILT_CYC = FILT_NS * CLK_MHZ / 1000;
    localparam int BROWNOUT_MIN_DURATION_NS = 200;
    localparam int BROWNOUT_MIN_DURATION_CYC = (BROWNOUT_MIN_DURATION_NS * CLK_MHZ + 999) / 1000;
    localparam int RC_PERIOD_US = 32;
    localparam int RC_TICK_CYC = RC_PERIOD_US * CLK_MHZ;
    localparam int POWERUP_DELAY_TIMER_BITS = 11;
    localparam int POR_PULSE_CYC = 4;

    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef struct packed {
        logic ext_reset_pin_enable;
        logic powerup_timer_disable_n;
        logic [1:0] brownout_level_cfg;
        logic [1:0] brownout_mode_cfg;
    } rsbc_cfg_t;

endpackage : rsbc_pkg

// *** dv/rsbc_board_model.sv ***
// Board-side model: supply comparators and the pulled-up reset pin.
// Assumes the bench sets the supply in millivolts and the pin pull.
`timescale 1ns/100ps
module rsbc_board_model #(
    parameter int POR_MV = 1500,
    parameter int LVL0_MV = 2000,
    parameter int LVL1_MV = 2700,
    parameter int LVL2_MV = 4200,
    parameter int LVL3_MV = 4500
) (
    input wire logic [15:0] vdd_mv,
    input wire logic pull_low,
    input wire logic [1:0] level_sel,
    output logic supply_ok,
    output logic supply_low,
    output logic pin_n
);
    int thr;

    always_comb begin
        case (level_sel)
            2'h0: thr = LVL0_MV;
            2'h1: thr = LVL1_MV;
            2'h2: thr = LVL2_MV;
            default: thr = LVL3_MV;
        endcase
    end

    assign supply_ok = int'(vdd_mv) > POR_MV;
    assign supply_low = int'(vdd_mv) < thr;
    // pin pulled up
    // The pin has a pull-up, so a released pin reads high, never stale.
    assign pin_n = !pull_low;
endmodule : rsbc_board_model

// *** dv/test_rsbc_top.sv ***
// Self-checking bench for the reset source and brown-out block.
// Assumes the board model drives the supply comparators and the pin.
`timescale 1ns/100ps
module test_rsbc_top;
    localparam int RC = 4;
    localparam int PC = 8;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic sleep = 1'b0;
    logic pull = 1'b0;
    logic [15:0] vdd = 16'h0000;
    rsbc_pkg::rsbc_cfg_t cfg = '0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, lvl, rs;
    logic pin_data, dev_rst, osc_startup_timer, sup_ok, sup_low, pin_n;
    int fails = 0, samples_checked = 0, ost_cnt = 0, n, en, k;
    logic [31:0] seed, d, exp_ctrl;
    logic [5:0] c;

    always #10 clk = ~clk;
    always @(posedge clk) if (osc_startup_timer === 1'b1) ost_cnt++;

    rsbc_board_model board (.vdd_mv(vdd), .pull_low(pull),
        .level_sel(lvl), .supply_ok(sup_ok), .supply_low(sup_low),
        .pin_n(pin_n));

    rsbc_top #(.RC_TICK(RC), .POWERUP_DELAY_TIMER_COUNT(PC)) uut (.CORE_CLK(clk),
        .RESETN(resetn), .EXT_RESET_N(pin_n), .SUPPLY_OK(sup_ok),
        .BOR_SUPPLY_LOW(sup_low), .SLEEP_MODE(sleep), .CFG(cfg),
        .BOR_LEVEL_SEL(lvl), .EXT_PIN_DATA(pin_data),
        .DEVICE_RESET(dev_rst), .OST_START(osc_startup_timer), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready));

    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] ex);
        samples_checked++;
        if (seen !== ex) begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, ex);
        end
    endtask : check

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic give_verdict;
        if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    // Both bus tasks start just after a rising edge and hold until taken.
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] v);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= v;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [31:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    // Counts cycles until the device leaves reset; the watchdog bounds it.
    task automatic wait_run(output int cnt);
        cnt = 0;
        do begin
            @(posedge clk);
            cnt++;
        end while (dev_rst !== 1'b0);
    endtask : wait_run

    task automatic power_up(input logic [5:0] cv);
        resetn <= 1'b0;
        vdd <= 16'h0000;
        pull <= 1'b0;
        cfg <= rsbc_pkg::rsbc_cfg_t'(cv);
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        repeat (5) @(posedge clk);
        vdd <= 16'h1388;
        wait_run(n);
    endtask : power_up

    ////////////////////////////////////////////////////////////////////
    initial begin
        #1_000_000;
        fails++;
        give_verdict();
    end

    initial begin
        seed = 32'hD417;
        for (int m = 0; m < 4; m++) begin
            for (int p = 0; p < 2; p++) begin
                c = {1'b1, 1'(p), 2'(rnd()), 2'(m)};
                k = ost_cnt;
                power_up(c);
                if (p == 0) check(32'(n >= 4 + PC * RC), 1);
                else check(32'(n < 4 + PC * RC), 1);
                axi_rd({28'h0, rsbc_pkg::CTRL_OFFS});
                check(ost_cnt, k + 1);
                check(32'(lvl), 32'(c[3:2]));
                check(d, (m == 1) ? 32'h40 : 32'h0);
                axi_wr({28'h0, rsbc_pkg::CTRL_OFFS}, p ? 32'h3 : 32'h43);
                check(32'(rs), 32'(rsbc_pkg::AXI_OKAY));
                exp_ctrl = (m == 1 && p == 0) ? 32'h43 : 32'h03;
                axi_rd({28'h0, rsbc_pkg::CTRL_OFFS});
                check(d, exp_ctrl);
                sleep <= 1'(p);
                k = 0;
                pull <= 1'b1;
                repeat (rnd() % 5 + 1) @(posedge clk);
                pull <= 1'b0;
                repeat (20) begin
                    @(posedge clk);
                    if (dev_rst !== 1'b0) k++;
                end
                check(k, 0);
                pull <= 1'b1;
                repeat (20) @(posedge clk);
                check(32'(dev_rst), 1);
                pull <= 1'b0;
                wait_run(n);
                axi_rd({28'h0, rsbc_pkg::CTRL_OFFS});
                check(d, exp_ctrl);
                // brown-out per mode, with a second drop mid-delay
                en = (m == 3) || (m != 0 && p == 0);
                vdd <= 16'h0708;
                repeat (30) @(posedge clk);
                check(32'(dev_rst), 32'(en));
                vdd <= 16'h1388;
                repeat (6) @(posedge clk);
                vdd <= 16'h0708;
                repeat (20) @(posedge clk);
                check(32'(dev_rst), 32'(en));
                vdd <= 16'h1388;
                wait_run(n);
                if (en && p == 0) check(32'(n >= PC * RC), 1);
                if (en && p == 1) check(32'(n < PC * RC), 1);
                axi_rd({28'h0, rsbc_pkg::CTRL_OFFS});
                check(d, en ? exp_ctrl & 32'h42 : exp_ctrl);
                if (en) check(32'(d[1:0]), 32'h2);
            end
        end
        sleep <= 1'b0;
        power_up(6'h10);
        pull <= 1'b1;
        k = 0;
        repeat (30) begin
            @(posedge clk);
            if (dev_rst !== 1'b0) k++;
        end
        check(k, 0);
        check(32'(pin_data), 0);
        pull <= 1'b0;
        axi_rd(32'h0000_0010);
        check(d, 32'h0);
        check(32'(rs), 32'(rsbc_pkg::AXI_SLVERR));
        axi_wr(32'h0000_0010, 32'h0);
        check(32'(rs), 32'(rsbc_pkg::AXI_SLVERR));
        axi_rd({28'h0, rsbc_pkg::CTRL_OFFS});
        check(32'(d[1:0]), 32'h0);
        give_verdict();
    end
endmodule : test_rsbc_top
